// >>> bright_pkg.sv
// Constants, register map and types of the LED brightness path
package bright_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_BRIGHT_CTRL = 8'h11;
  localparam logic [7:0] ADDR_PWM_CFG = 8'h12;
  localparam logic [7:0] ADDR_BOOST_CFG = 8'h13;
  localparam logic [7:0] ADDR_BRT_LOW = 8'h18;
  localparam logic [7:0] ADDR_BRT_HIGH = 8'h19;
  localparam logic [7:0] RST_BRIGHT_CTRL = 8'h00;
  localparam logic [7:0] RST_PWM_CFG = 8'h00;
  localparam logic [7:0] RST_BOOST_CFG = 8'h00;
  localparam logic [7:0] RST_BRT_LOW = 8'h00;
  localparam logic [7:0] RST_BRT_HIGH = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int RAMP_LSB = 2;
  localparam int SRATE_LSB = 6;
  localparam int IND_BIT = 4;
  localparam int FSW_BIT = 5;
  localparam int SHIFT_BIT = 6;
  localparam int LOW_BITS = 3;
  localparam int CODE_W = 11;
  localparam logic [10:0] CODE_MAX = 11'h7FF;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PER_US = CLK_HZ / 1000000;
  localparam int RATE_SLOW_HZ = 800000;
  localparam int RATE_MID_HZ = 4000000;
  localparam int RATE_FAST_HZ = 24000000;
  localparam logic [4:0] DIV_SLOW = 5'((CLK_HZ + RATE_SLOW_HZ - 1) / RATE_SLOW_HZ - 1);
  localparam logic [4:0] DIV_MID = 5'((CLK_HZ + RATE_MID_HZ - 1) / RATE_MID_HZ - 1);
  localparam logic [4:0] DIV_FAST = 5'((CLK_HZ + RATE_FAST_HZ - 1) / RATE_FAST_HZ - 1);
  localparam int TIMEOUT_SLOW_US = 25000;
  localparam int TIMEOUT_MID_US = 3000;
  localparam int TIMEOUT_FAST_US = 600;
  // Time per ramp step in microseconds, fastest first
  localparam int STEP_US [8] = '{1, 64, 128, 256, 512, 1000, 2000, 4000};
  localparam int STEP_W = 24;
  typedef enum logic [1:0] {MODE_HOST, MODE_PWM, MODE_MUL_RAMP, MODE_RAMP_MUL} bright_mode_t;
  typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;
endpackage

// >>> led_brightness_path.sv
// Brightness path: register file, PWM duty sampler, timeout, ramper, mixer
`timescale 1ns/1ps
// What this block does
// - Full-scale PWM step settles in about 2 ms at the fastest ramp rate
// - Boost off when PWM pulses stop, except in mode 00
// - Timeout 25, 3 or 0.6 ms per rate
// - Eight ramp rates, each a time per step
// - Ramp time is step time times (diff-1)
// - Two-bit mode picks one of four sources
// - Mode 00 uses host code, ignores PWM
// - Code is low 3 bits plus high byte
// - Only high-byte write applies new code
// - Mode 00 ramper spaces host set-points only
// - Mode 01 uses duty only, ignores host
// - Duty is measured into an 11-bit code
// - Mode 10 multiplies, then ramps the product
// - Mode 11 ramps host code, then scales
// - Config bit 5 picks 500 kHz or 1 MHz
// - Config bit 6 lowers frequency by 12 percent
// - PWM sample rate chosen by bits 7:6
module led_brightness_path
  import bright_pkg::*;
#(
  parameter int CYC_PER_US = CLK_PER_US,
  parameter int TIMEOUT_SLOW_CYC = TIMEOUT_SLOW_US * CLK_PER_US,
  parameter int TIMEOUT_MID_CYC = TIMEOUT_MID_US * CLK_PER_US,
  parameter int TIMEOUT_FAST_CYC = TIMEOUT_FAST_US * CLK_PER_US
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic PWM_IN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic [10:0] LED_CODE,
  output logic BOOST_EN,
  output logic FSW_1MHZ,
  output logic FSW_SHIFT,
  output logic MIN_IND_10UH
);
  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (CYC_PER_US < 1 || STEP_US[7] * CYC_PER_US >= 2 ** STEP_W) begin : bad_step
    $error("CYC_PER_US out of range");
  end
  if (TIMEOUT_SLOW_CYC < 1 || TIMEOUT_SLOW_CYC >= 2 ** 20 || TIMEOUT_MID_CYC < 1 ||
      TIMEOUT_FAST_CYC < 1) begin : bad_timeout
    $error("Timeout counts out of range");
  end

  logic [7:0] bright_ctrl;
  logic [7:0] pwm_cfg;
  logic [7:0] boost_cfg;
  logic [7:0] brt_low;
  logic [7:0] brt_high;
  logic [10:0] host_code;
  logic [10:0] duty_code;
  logic [10:0] ramp_code;
  logic [10:0] target;
  logic [STEP_W-1:0] step_cnt;
  logic [STEP_W-1:0] step_len;
  logic step_now;
  logic [4:0] smp_div;
  logic [4:0] smp_limit;
  logic smp_tick;
  logic pwm_smp;
  logic pwm_rise;
  logic [15:0] period_cnt;
  logic [15:0] high_cnt;
  logic [15:0] div_den;
  logic [16:0] div_rem;
  logic [3:0] div_bits;
  logic [10:0] div_quo;
  logic [16:0] next_rem;
  div_state_t div_state;
  logic [19:0] idle_cnt;
  logic [19:0] idle_limit;
  logic pwm_lost;
  bright_mode_t mode;
  assign mode = bright_mode_t'(bright_ctrl[MODE_LSB +: 2]);
  // Scale a code by duty; duty+1 makes full duty exact
  function automatic logic [10:0] scale(input logic [10:0] code, input logic [10:0] duty);
    logic [22:0] prod;
    prod = 23'(code) * 23'({1'b0, duty} + 12'h001);
    return prod[CODE_W +: CODE_W];
  endfunction
  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bright_ctrl <= RST_BRIGHT_CTRL;
      pwm_cfg <= RST_PWM_CFG;
      boost_cfg <= RST_BOOST_CFG;
      brt_low <= RST_BRT_LOW;
      brt_high <= RST_BRT_HIGH;
    end else if (REG_WR) begin
      case (REG_ADDR)
        ADDR_BRIGHT_CTRL: bright_ctrl <= REG_WDATA;
        ADDR_PWM_CFG: pwm_cfg <= REG_WDATA;
        ADDR_BOOST_CFG: boost_cfg <= REG_WDATA;
        ADDR_BRT_LOW: brt_low <= REG_WDATA;
        ADDR_BRT_HIGH: brt_high <= REG_WDATA;
        default: ;
      endcase
    end
  end
  // Host code is latched only by the high-byte write, so the pair lands atomically
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      host_code <= {RST_BRT_HIGH, RST_BRT_LOW[LOW_BITS-1:0]};
    end else if (REG_WR && REG_ADDR == ADDR_BRT_HIGH) begin
      host_code <= {REG_WDATA, brt_low[LOW_BITS-1:0]};
    end
  end
  // Read port; unmapped addresses read zero
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= READ_UNMAPPED;
    end else if (REG_RD) begin
      case (REG_ADDR)
        ADDR_BRIGHT_CTRL: REG_RDATA <= bright_ctrl;
        ADDR_PWM_CFG: REG_RDATA <= pwm_cfg;
        ADDR_BOOST_CFG: REG_RDATA <= boost_cfg;
        ADDR_BRT_LOW: REG_RDATA <= brt_low;
        ADDR_BRT_HIGH: REG_RDATA <= brt_high;
        default: REG_RDATA <= READ_UNMAPPED;
      endcase
    end
  end
  // Boost configuration pins, one cycle behind the register
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FSW_1MHZ <= RST_BOOST_CFG[FSW_BIT];
      FSW_SHIFT <= RST_BOOST_CFG[SHIFT_BIT];
      MIN_IND_10UH <= RST_BOOST_CFG[IND_BIT];
    end else begin
      FSW_1MHZ <= boost_cfg[FSW_BIT];
      FSW_SHIFT <= boost_cfg[SHIFT_BIT];
      MIN_IND_10UH <= boost_cfg[IND_BIT];
    end
  end

  // ------------------------------------------------------------------
  // PWM sampling and duty measurement
  // ------------------------------------------------------------------
  // Rate 1X means fastest; both upper codes share it
  always_comb begin
    case (pwm_cfg[SRATE_LSB +: 2])
      2'h0: begin
        smp_limit = DIV_SLOW;
        idle_limit = 20'(TIMEOUT_SLOW_CYC);
      end
      2'h1: begin
        smp_limit = DIV_MID;
        idle_limit = 20'(TIMEOUT_MID_CYC);
      end
      default: begin
        smp_limit = DIV_FAST;
        idle_limit = 20'(TIMEOUT_FAST_CYC);
      end
    endcase
  end
  assign smp_tick = (smp_div >= smp_limit);
  assign pwm_rise = smp_tick && PWM_IN && !pwm_smp;
  // Sample clock divider and sampled level
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      smp_div <= 5'h00;
      pwm_smp <= 1'b0;
    end else begin
      smp_div <= smp_tick ? 5'h00 : smp_div + 5'h01;
      if (smp_tick) begin
        pwm_smp <= PWM_IN;
      end
    end
  end
  // Period and high-time counters, restarted at each rising edge; they saturate
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      period_cnt <= 16'h0000;
      high_cnt <= 16'h0000;
    end else if (pwm_rise) begin
      period_cnt <= 16'h0001;
      high_cnt <= 16'h0001;
    end else if (smp_tick) begin
      if (period_cnt != 16'hFFFF) begin
        period_cnt <= period_cnt + 16'h0001;
      end
      if (PWM_IN && high_cnt != 16'hFFFF) begin
        high_cnt <= high_cnt + 16'h0001;
      end
    end
  end
  // Serial divider: eleven fraction bits of high/period, full duty gives 7FF
  assign next_rem = {div_rem[15:0], 1'b0};
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_state <= DIV_IDLE;
      div_rem <= 17'h00000;
      div_den <= 16'h0000;
      div_bits <= 4'h0;
      div_quo <= 11'h000;
      duty_code <= 11'h000;
    end else begin
      case (div_state)
        DIV_IDLE: begin
          // First edge has no full period behind it
          if (pwm_rise && period_cnt != 16'h0000) begin
            div_rem <= {1'b0, high_cnt};
            div_den <= period_cnt;
            div_bits <= 4'(CODE_W);
            div_state <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          if (next_rem >= {1'b0, div_den}) begin
            div_rem <= next_rem - {1'b0, div_den};
            div_quo <= {div_quo[9:0], 1'b1};
          end else begin
            div_rem <= next_rem;
            div_quo <= {div_quo[9:0], 1'b0};
          end
          div_bits <= div_bits - 4'h1;
          if (div_bits == 4'h1) begin
            duty_code <= (next_rem >= {1'b0, div_den}) ? {div_quo[9:0], 1'b1} :
                         {div_quo[9:0], 1'b0};
            div_state <= DIV_IDLE;
          end
        end
        default: div_state <= DIV_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // PWM absence timeout
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      idle_cnt <= 20'h00000;
      pwm_lost <= 1'b0;
    end else if (pwm_rise) begin
      idle_cnt <= 20'h00000;
      pwm_lost <= 1'b0;
    end else if (idle_cnt >= idle_limit) begin
      pwm_lost <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + 20'h00001;
    end
  end
  // Host-only mode never looks at the PWM pin, so it never times out
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BOOST_EN <= 1'b1;
    end else begin
      BOOST_EN <= !(mode != MODE_HOST && pwm_lost);
    end
  end

  // ------------------------------------------------------------------
  // Ramper
  // ------------------------------------------------------------------
  always_comb begin
    case (mode)
      MODE_HOST: target = host_code;
      MODE_PWM: target = duty_code;
      MODE_MUL_RAMP: target = scale(host_code, duty_code);
      MODE_RAMP_MUL: target = host_code;
      default: target = host_code;
    endcase
  end
  // Fastest rate of 1 us per step covers full scale in about 2 ms
  assign step_len = STEP_W'(STEP_US[bright_ctrl[RAMP_LSB +: 3]] * CYC_PER_US);
  assign step_now = (ramp_code != target) && (step_cnt == '0);
  // First step is immediate, so a diff of N codes takes (N-1) intervals
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ramp_code <= 11'h000;
      step_cnt <= '0;
    end else begin
      if (step_now) begin
        ramp_code <= (target > ramp_code) ? ramp_code + 11'h001 : ramp_code - 11'h001;
        step_cnt <= step_len - STEP_W'(1);
      end else if (step_cnt != '0) begin
        step_cnt <= step_cnt - STEP_W'(1);
      end
    end
  end
  // Mode 11 scales after the ramper, so duty changes apply at once
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LED_CODE <= 11'h000;
    end else begin
      LED_CODE <= (mode == MODE_RAMP_MUL) ? scale(ramp_code, duty_code) : ramp_code;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  chk_boost_timeout: assert property (mode != MODE_HOST && pwm_lost && $stable(mode)
    |=> !BOOST_EN) else $error("boost not off after timeout");
  chk_host_mode_boost: assert property (mode == MODE_HOST |=> BOOST_EN)
    else $error("boost off in host mode");
  chk_timeout_limit: assert property ($rose(pwm_lost) |-> $past(idle_cnt) >= $past(idle_limit))
    else $error("timeout fired early");
  chk_high_write: assert property (REG_WR && REG_ADDR == ADDR_BRT_HIGH
    |=> host_code == {$past(REG_WDATA), $past(brt_low[2:0])}) else $error("bad code");
  chk_low_write: assert property (REG_WR && REG_ADDR == ADDR_BRT_LOW |=> $stable(host_code))
    else $error("low write moved code");
  chk_ramp_unit: assert property (ramp_code != $past(ramp_code)
    |-> ramp_code == $past(ramp_code) + 11'h001 || ramp_code == $past(ramp_code) - 11'h001)
    else $error("ramp jumped");
  chk_ramp_space: assert property (step_now |=> step_cnt == $past(step_len) - STEP_W'(1))
    else $error("step interval wrong");
  chk_pwm_target: assert property (mode == MODE_PWM |-> target == duty_code)
    else $error("mode 01 target");
  chk_mul_target: assert property (mode == MODE_MUL_RAMP
    |-> target == scale(host_code, duty_code)) else $error("mode 10 target");
  chk_post_scale: assert property (mode == MODE_RAMP_MUL
    |=> LED_CODE == scale($past(ramp_code), $past(duty_code))) else $error("mode 11");
  chk_freq_pins: assert property (##1 FSW_1MHZ == $past(boost_cfg[FSW_BIT])
    && FSW_SHIFT == $past(boost_cfg[SHIFT_BIT])) else $error("boost pins");
  cov_timeout: cover property (mode == MODE_PWM ##1 $fell(BOOST_EN));
  cov_duty_done: cover property (div_state == DIV_RUN ##1 div_state == DIV_IDLE);
  cov_ramp_mul: cover property (mode == MODE_RAMP_MUL && step_now);
  cov_ramp_down: cover property (step_now && target < ramp_code);
endmodule

// >>> host_pwm.sv
// Host-side model: logic-level PWM source feeding the brightness path
`timescale 1ns/1ps
module host_pwm (
  input wire logic clk,
  input wire logic run,
  input wire integer high_cyc,
  input wire integer period_cyc,
  output logic pwm
);
  int cnt = 0;
  // ------------------------------------------------------------------
  // Period generator
  // ------------------------------------------------------------------
  // Stepped on the falling edge so the level is settled at each sample
  always @(negedge clk) begin
    if (run && period_cyc > 0) begin
      cnt <= (cnt + 1 >= period_cyc) ? 0 : cnt + 1;
      pwm <= (cnt < high_cyc);
    end else begin
      cnt <= 0;
      pwm <= 1'b0; // Stopped source rests low, no further rising edge
    end
  end
  initial pwm = 1'b0;
endmodule

// >>> led_brightness_path_bench.sv
// Self-checking bench for the LED brightness path
`timescale 1ns/1ps
module led_brightness_path_bench
  import bright_pkg::*;
;
  localparam int TMO [3] = '{200, 100, 50};
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic [10:0] LED_CODE;
  logic BOOST_EN, FSW_1MHZ, FSW_SHIFT, MIN_IND_10UH, PWM_IN;
  logic pwm_run = 1'b1;
  logic rd_seen = 1'b0;
  int pwm_high = 20;
  int pwm_period = 40;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] exp_q [$];
  logic [7:0] v;
  logic [7:0] addrs [5];

  always #20 CORE_CLK = ~CORE_CLK;

  led_brightness_path #(.CYC_PER_US(1), .TIMEOUT_SLOW_CYC(TMO[0]),
    .TIMEOUT_MID_CYC(TMO[1]), .TIMEOUT_FAST_CYC(TMO[2])) led_brightness_path_i (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PWM_IN(PWM_IN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .LED_CODE(LED_CODE), .BOOST_EN(BOOST_EN), .FSW_1MHZ(FSW_1MHZ),
    .FSW_SHIFT(FSW_SHIFT), .MIN_IND_10UH(MIN_IND_10UH));

  host_pwm host_pwm_i (.clk(CORE_CLK), .run(pwm_run), .high_cyc(pwm_high),
    .period_cyc(pwm_period), .pwm(PWM_IN));

  // ------------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read data lands one cycle after the strobe; oldest note is compared
  always @(posedge CORE_CLK) rd_seen <= REG_RD;
  always @(negedge CORE_CLK) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unnoted read", 11'h7FF, 11'h000);
      end else begin
        check("read data", {3'h0, REG_RDATA}, {3'h0, exp_q.pop_front()});
      end
    end
  end

  // ------------------------------------------------------------------
  // Register bus tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CORE_CLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CORE_CLK);
    REG_WR = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge CORE_CLK);
    exp_q.push_back(e);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CORE_CLK);
    REG_RD = 1'b0;
  endtask

  // Low bits first, then the high byte that applies the code
  task automatic set_code(input logic [10:0] c);
    wr(ADDR_BRT_LOW, {5'h00, c[2:0]});
    wr(ADDR_BRT_HIGH, c[10:3]);
  endtask

  // Hang guard, about twice the length of the sequence
  initial begin
    repeat (30000) @(posedge CORE_CLK);
    bad_count++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(16414));
    addrs = '{ADDR_BRIGHT_CTRL, ADDR_PWM_CFG, ADDR_BOOST_CFG, ADDR_BRT_LOW, ADDR_BRT_HIGH};
    repeat (3) @(negedge CORE_CLK);
    RESET_N = 1'b1;
    // Reset values of every register, the boost enable and the LED code
    rd(ADDR_BRIGHT_CTRL, RST_BRIGHT_CTRL);
    rd(ADDR_PWM_CFG, RST_PWM_CFG);
    rd(ADDR_BOOST_CFG, RST_BOOST_CFG);
    rd(ADDR_BRT_LOW, RST_BRT_LOW);
    rd(ADDR_BRT_HIGH, RST_BRT_HIGH);
    check("boost after reset", {10'h0, BOOST_EN}, 11'h001);
    check("code after reset", LED_CODE, 11'h000);
    // Random read-back, plus an unmapped place that reads as zero
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      wr(addrs[i], v);
      rd(addrs[i], v);
    end
    wr(8'h20, 8'($urandom));
    rd(8'h20, READ_UNMAPPED);
    // Every combination of the three boost configuration bits
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_BOOST_CFG, {1'b0, 3'(i), 4'h0});
      // Pins follow the register one cycle later
      @(negedge CORE_CLK);
      check("freq shift", {10'h0, FSW_SHIFT}, 11'(i[2]));
      check("freq 1MHz", {10'h0, FSW_1MHZ}, 11'(i[1]));
      check("inductor", {10'h0, MIN_IND_10UH}, 11'(i[0]));
    end
    // Host-only mode, PWM running meanwhile and ignored
    wr(ADDR_PWM_CFG, 8'h80);
    wr(ADDR_BRIGHT_CTRL, 8'h00);
    set_code(11'd21);
    // Random setup may leave a 4000-cycle step pending and a far code
    repeat (6200) @(negedge CORE_CLK);
    check("host code", LED_CODE, 11'd21);
    wr(ADDR_BRT_LOW, 8'h00);
    repeat (50) @(negedge CORE_CLK);
    check("low bits only", LED_CODE, 11'd21);
    // Slower rate: 64 cycles per step from 21 towards 31
    wr(ADDR_BRIGHT_CTRL, 8'h04);
    set_code(11'd31);
    repeat (224) @(negedge CORE_CLK);
    check("ramp midway", LED_CODE, 11'd25);
    repeat (448) @(negedge CORE_CLK);
    check("ramp end", LED_CODE, 11'd31);
    // PWM-only mode: half then three-quarter duty
    wr(ADDR_BRIGHT_CTRL, 8'h01);
    repeat (1200) @(negedge CORE_CLK);
    check("half duty", LED_CODE, 11'h400);
    pwm_high = 30;
    repeat (800) @(negedge CORE_CLK);
    check("duty step", LED_CODE, 11'h600);
    // Multiply then ramp, host 0x400 at half duty
    pwm_high = 20;
    set_code(11'h400);
    wr(ADDR_BRIGHT_CTRL, 8'h02);
    repeat (1200) @(negedge CORE_CLK);
    check("mul ramp", LED_CODE, 11'd512);
    // Ramp then multiply: duty change applies at once even at the slowest rate
    wr(ADDR_BRIGHT_CTRL, 8'h03);
    repeat (700) @(negedge CORE_CLK);
    check("ramp mul", LED_CODE, 11'd512);
    wr(ADDR_BRIGHT_CTRL, 8'h1F);
    pwm_high = 30;
    repeat (200) @(negedge CORE_CLK);
    check("duty unramped", LED_CODE, 11'd768);
    // Multiply then ramp at the slowest rate keeps the change slow
    wr(ADDR_BRIGHT_CTRL, 8'h1E);
    pwm_high = 20;
    repeat (200) @(negedge CORE_CLK);
    check("product ramped", {10'h0, LED_CODE > 11'd1000}, 11'h001);
    // Pulse loss at each rate code; codes 2 and 3 both pick the fastest rate
    wr(ADDR_BRIGHT_CTRL, 8'h01);
    for (int r = 0; r < 4; r++) begin
      int k;
      int w;
      k = (r > 2) ? 2 : r;
      // Slow sampling would miss short pulses, so that rate gets long ones
      pwm_period = (k == 0) ? 160 : 40;
      pwm_high = pwm_period / 2;
      // Stop once the last pulse is surely sampled, clear of its edges
      w = (k == 0) ? 40 : 30;
      wr(ADDR_PWM_CFG, {2'(r), 6'h00});
      repeat (100) @(negedge CORE_CLK);
      @(posedge PWM_IN);
      repeat (w) @(negedge CORE_CLK);
      pwm_run = 1'b0;
      repeat (TMO[k] * 6 / 10 - w) @(negedge CORE_CLK);
      check("boost before timeout", {10'h0, BOOST_EN}, 11'h001);
      repeat (TMO[k] * 9 / 10 + 40) @(negedge CORE_CLK);
      check("boost after timeout", {10'h0, BOOST_EN}, 11'h000);
      pwm_run = 1'b1;
      repeat (100) @(negedge CORE_CLK);
      check("boost on resume", {10'h0, BOOST_EN}, 11'h001);
    end
    // Host-only mode never times out
    wr(ADDR_BRIGHT_CTRL, 8'h00);
    pwm_run = 1'b0;
    repeat (300) @(negedge CORE_CLK);
    check("boost host mode", {10'h0, BOOST_EN}, 11'h001);
    repeat (4) @(negedge CORE_CLK);
    finish_test();
  end
endmodule
